// ---- hw/fifo_chan.sv ----
// One FIFO channel: pins sampled by the system clock, storage and flags
`timescale 1ns/1ps
module fifo_chan
	import fifo_chan_pkg::*;
(
	input wire logic sys_clk_i, // System clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic rs_n_i, // Channel reset pin, active low
	input wire logic wr_clock_i, // Write clock pin
	input wire logic rd_clock_i, // Read clock pin
	input wire logic wr_enable_first_i, // First write enable, active low
	input wire logic wr_enable2_or_load_i, // Second enable or load control
	input wire logic rd_enable_first_i, // First read enable, active low
	input wire logic rd_enable_second_i, // Second read enable, active low
	input wire logic out_drive_n_i, // Output enable, active low
	input wire logic [DATA_W-1:0] wr_data_bus_i, // Write data pins
	output logic [DATA_W-1:0] rd_data_bus_o, // Read data pins
	output logic rd_data_oe_n_o, // Low while read data is driven
	output logic empty_flag_n_o, // Low when empty
	output logic almost_empty_flag_n_o, // Low when almost empty
	output logic almost_full_flag_n_o, // Low when almost full
	output logic full_flag_n_o // Low when full
);

	// Whole channel state; one instance shares nothing with another
	typedef struct packed {
		logic [PIN_W-1:0] sync1; // First synchroniser stage
		logic [PIN_W-1:0] sync2; // Second synchroniser stage
		logic wclk_prev; // Write clock, one sample back
		logic rclk_prev; // Read clock, one sample back
		logic [DEPTH-1:0][DATA_W-1:0] mem; // Storage array
		logic [ADDR_W-1:0] wptr; // Write pointer
		logic [ADDR_W-1:0] rptr; // Read pointer
		logic [CNT_W-1:0] count; // Words held
		logic mode_pf; // High when pin is load control
		logic off_sel; // Next offset to load or read
		logic [ADDR_W-1:0] ae_off; // Almost-empty offset
		logic [ADDR_W-1:0] af_off; // Almost-full offset
		logic [DATA_W-1:0] q; // Read data register
		logic oe_n; // Output enable register
		logic ef_n; // Empty flag
		logic pae_n; // Almost-empty flag
		logic paf_n; // Almost-full flag
		logic ff_n; // Full flag
	} chan_state_t;

	chan_state_t st_reg; // Registered state
	chan_state_t st_next; // Next state

	logic [PIN_W-1:0] pins; // Raw pin vector
	logic wr_edge; // Rising write clock seen
	logic rd_edge; // Rising read clock seen
	logic wr_en; // Write qualifiers met
	logic rd_en; // Read qualifiers met
	logic do_wr; // Word is stored this cycle
	logic do_rd; // Word is read this cycle
	logic ld_wr; // Offset load this cycle
	logic ld_rd; // Offset readback this cycle
	logic in_rs; // Channel reset pin held low
	logic [CNT_W-1:0] cnt_new; // Fill level after this cycle

	// Gather the pins so they pass the synchroniser together
	assign pins = {rs_n_i, out_drive_n_i, rd_enable_second_i,
		rd_enable_first_i, wr_enable2_or_load_i, wr_enable_first_i,
		rd_clock_i, wr_clock_i, wr_data_bus_i};

	// Qualifiers taken from the second synchroniser stage only
	always_comb
	begin
		wr_edge = st_reg.sync2[P_WCLK] & ~st_reg.wclk_prev;
		rd_edge = st_reg.sync2[P_RCLK] & ~st_reg.rclk_prev;
		in_rs = ~st_reg.sync2[P_RS_N];
		// Flag mode: first enable only, load high; else both enables
		if (st_reg.mode_pf)
		begin
			wr_en = ~st_reg.sync2[P_WEN1] & st_reg.sync2[P_WEN2LD];
		end
		else
		begin
			wr_en = ~st_reg.sync2[P_WEN1] & st_reg.sync2[P_WEN2LD];
		end
		rd_en = ~st_reg.sync2[P_REN1] & ~st_reg.sync2[P_REN2];
		do_wr = wr_edge & wr_en & st_reg.ff_n & ~in_rs;
		// Offset readback uses the read port but leaves the words alone
		do_rd = rd_edge & rd_en & st_reg.ef_n & ~in_rs
			& ~(st_reg.mode_pf & ~st_reg.sync2[P_WEN2LD]);
		// Load control held low by the writer selects offset access
		ld_wr = st_reg.mode_pf & wr_edge & ~st_reg.sync2[P_WEN2LD]
			& ~st_reg.sync2[P_WEN1] & ~in_rs;
		ld_rd = st_reg.mode_pf & rd_edge & ~st_reg.sync2[P_WEN2LD]
			& rd_en & ~in_rs;
		cnt_new = st_reg.count + {{(CNT_W-1){1'b0}}, do_wr}
			- {{(CNT_W-1){1'b0}}, do_rd};
	end

	// Next-state logic for the whole channel
	always_comb
	begin
		st_next = st_reg;
		st_next.sync1 = pins;
		st_next.sync2 = st_reg.sync1;
		st_next.wclk_prev = st_reg.sync2[P_WCLK];
		st_next.rclk_prev = st_reg.sync2[P_RCLK];
		st_next.oe_n = st_reg.sync2[P_OE_N];
		if (in_rs)
		begin
			// Channel reset: pointers home, flags to reset levels
			st_next.wptr = '0;
			st_next.rptr = '0;
			st_next.count = '0;
			st_next.ff_n = 1'b1;
			st_next.paf_n = 1'b1;
			st_next.ef_n = 1'b0;
			st_next.pae_n = 1'b0;
			st_next.ae_off = AE_OFF_RST;
			st_next.af_off = AF_OFF_RST;
			st_next.off_sel = 1'b0;
			st_next.mode_pf = ~st_reg.sync2[P_WEN2LD];
		end
		else
		begin
			// Store a word from the write data pins
			if (do_wr)
			begin
				st_next.mem[st_reg.wptr] = st_reg.sync2[P_DATA +: DATA_W];
				st_next.wptr = st_reg.wptr + 8'h01;
			end
			// Present the oldest word on the read data register
			if (do_rd)
			begin
				st_next.q = st_reg.mem[st_reg.rptr];
				st_next.rptr = st_reg.rptr + 8'h01;
			end
			st_next.count = cnt_new;
			// Offset load alternates between the two offsets
			if (ld_wr)
			begin
				if (st_reg.off_sel)
				begin
					st_next.af_off = st_reg.sync2[P_DATA +: ADDR_W];
				end
				else
				begin
					st_next.ae_off = st_reg.sync2[P_DATA +: ADDR_W];
				end
				st_next.off_sel = ~st_reg.off_sel;
			end
			else if (ld_rd)
			begin
				// Offset readback on the read data register
				if (st_reg.off_sel)
				begin
					st_next.q = {1'b0, st_reg.af_off};
				end
				else
				begin
					st_next.q = {1'b0, st_reg.ae_off};
				end
				st_next.off_sel = ~st_reg.off_sel;
			end
			// Read-side flags move only on read clock edges
			if (rd_edge)
			begin
				st_next.ef_n = (cnt_new != '0);
				st_next.pae_n = (cnt_new > {1'b0, st_reg.ae_off});
			end
			// Write-side flags move only on write clock edges
			if (wr_edge)
			begin
				st_next.ff_n = (cnt_new != DEPTH_CNT);
				st_next.paf_n = (cnt_new < (DEPTH_CNT
					- {1'b0, st_reg.af_off}));
			end
		end
	end

	// State register with synchronous system reset
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			st_reg <= '0;
			st_reg.sync1[P_RS_N] <= 1'b1;
			st_reg.sync2[P_RS_N] <= 1'b1;
			// Enables start inactive so no request is seen after reset
			st_reg.sync1[P_WEN1] <= 1'b1;
			st_reg.sync2[P_WEN1] <= 1'b1;
			st_reg.sync1[P_REN1] <= 1'b1;
			st_reg.sync2[P_REN1] <= 1'b1;
			st_reg.sync1[P_REN2] <= 1'b1;
			st_reg.sync2[P_REN2] <= 1'b1;
			// Output enable starts off so the data pins stay released
			st_reg.sync1[P_OE_N] <= 1'b1;
			st_reg.sync2[P_OE_N] <= 1'b1;
			st_reg.oe_n <= 1'b1;
			st_reg.ff_n <= 1'b1;
			st_reg.paf_n <= 1'b1;
			st_reg.ae_off <= AE_OFF_RST;
			st_reg.af_off <= AF_OFF_RST;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from state flip-flops
	assign rd_data_bus_o = st_reg.q;
	assign rd_data_oe_n_o = st_reg.oe_n;
	assign empty_flag_n_o = st_reg.ef_n;
	assign almost_empty_flag_n_o = st_reg.pae_n;
	assign almost_full_flag_n_o = st_reg.paf_n;
	assign full_flag_n_o = st_reg.ff_n;

endmodule : fifo_chan

// ---- hw/fifo_chan_pkg.sv ----
// Constants for one pin-level channel of the dual synchronous 9-bit FIFO
// Contract
// - Load pin sampled in reset picks mode
// - Two-enable mode: first low, second high
// - Writes ignored while full flag low
// - Read when both read enables low
// - Reads suppressed while empty flag low
// - Output enable low drives data, else off
// - Nine-bit read data from own storage
// - Empty flag low when empty, read-clock timed
// - Almost-empty low at/below offset, default seven
// - Almost-full low at full offset, default seven
// - Full flag low when full, write-clock timed
// - Reset zeroes pointers, sets flag levels
// - Flag mode: first write enable alone qualifies (code also needs load pin high)
// - Nine-bit write data into own storage
package fifo_chan_pkg;
	localparam int DATA_W = 9;
	localparam int DEPTH = 256;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 9;
	localparam logic [CNT_W-1:0] DEPTH_CNT = 9'h100;
	localparam logic [ADDR_W-1:0] AE_OFF_RST = 8'h07;
	localparam logic [ADDR_W-1:0] AF_OFF_RST = 8'h07;
	// Bit positions inside the synchronised pin vector
	localparam int PIN_W = 17;
	localparam int P_DATA = 0;
	localparam int P_WCLK = 9;
	localparam int P_RCLK = 10;
	localparam int P_WEN1 = 11;
	localparam int P_WEN2LD = 12;
	localparam int P_REN1 = 13;
	localparam int P_REN2 = 14;
	localparam int P_OE_N = 15;
	localparam int P_RS_N = 16;
endpackage : fifo_chan_pkg

// ---- tb/fifo_chan_assertions.sv ----
// Checker for one channel, bound to its ports
`timescale 1ns/1ps
module fifo_chan_assertions
	import fifo_chan_pkg::*;
(
	input wire logic sys_clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic rs_n_i, // Channel reset
	input wire logic wr_clock_i, // Write clock
	input wire logic rd_clock_i, // Read clock
	input wire logic out_drive_n_i, // Output enable
	input wire logic [DATA_W-1:0] rd_data_bus_o, // Read data
	input wire logic rd_data_oe_n_o, // Drive enable
	input wire logic empty_flag_n_o, // Empty
	input wire logic almost_empty_flag_n_o, // Almost empty
	input wire logic almost_full_flag_n_o, // Almost full
	input wire logic full_flag_n_o // Full
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i || !rs_n_i);
	AST_OE_COPY: assert property (rd_data_oe_n_o ==
		$past(out_drive_n_i, 3)) else $error("drive enable wrong");
	AST_EF_RD: assert property ($changed(empty_flag_n_o) |->
		$past(rd_clock_i, 3) || $past(rd_clock_i, 4)) else $error("ef");
	AST_PAE_RD: assert property ($changed(almost_empty_flag_n_o) |->
		$past(rd_clock_i, 3) || $past(rd_clock_i, 4)) else $error("pae");
	AST_FF_WR: assert property ($changed(full_flag_n_o) |->
		$past(wr_clock_i, 3) || $past(wr_clock_i, 4)) else $error("ff");
	AST_PAF_WR: assert property ($changed(almost_full_flag_n_o) |->
		$past(wr_clock_i, 3) || $past(wr_clock_i, 4)) else $error("paf");
	AST_Q_RD: assert property ($changed(rd_data_bus_o) |->
		$past(rd_clock_i, 3) || $past(rd_clock_i, 4)) else $error("q");
	AST_FULL_AF: assert property (!full_flag_n_o |->
		!almost_full_flag_n_o) else $error("full without almost full");
	AST_EMPTY_AE: assert property (!empty_flag_n_o |->
		!almost_empty_flag_n_o) else $error("empty without almost empty");
endmodule : fifo_chan_assertions
bind fifo_chan fifo_chan_assertions chk_i (.*);

// ---- tb/pin_clocks.sv ----
// Free-running pin clocks of the producer and the consumer
`timescale 1ns/1ps
module pin_clocks (
	output logic wr_clock_o, // Write clock, 80 ns
	output logic rd_clock_o // Read clock, 80 ns, offset phase
);
	// Producer clock
	initial
	begin
		wr_clock_o = 0;
		forever #40 wr_clock_o = ~wr_clock_o;
	end
	// Consumer clock, shifted so edges never line up
	initial
	begin
		rd_clock_o = 0;
		#17;
		forever #40 rd_clock_o = ~rd_clock_o;
	end
endmodule : pin_clocks

// ---- tb/tb.sv ----
// Bench for two channels driven through their pins
`timescale 1ns/1ps
module tb;
	import fifo_chan_pkg::*;
	logic sys_clk_i = 0, rst_i = 1, rs_n_i = 1, out_drive_n_i = 1; // Ctl
	logic wr_enable_first_i = 1, wr_enable2_or_load_i = 1; // Write pins
	logic rd_enable_first_i = 1, rd_enable_second_i = 1; // Read pins
	logic [DATA_W-1:0] wr_data_bus_i = '0, rd_data_bus_o; // Data pins
	logic wr_clock_i, rd_clock_i, rd_data_oe_n_o, ef_b; // Clocks, misc
	logic empty_flag_n_o, almost_empty_flag_n_o; // Read side flags
	logic almost_full_flag_n_o, full_flag_n_o; // Write side flags
	logic [DATA_W-1:0] fifo_q[$]; // Expected contents
	logic [ADDR_W-1:0] off[2]; // Expected offsets
	logic pf, tog; // Mode and offset pointer
	int num_errors = 0, comparisons = 0, seed = 52;
	pin_clocks src (.wr_clock_o(wr_clock_i), .rd_clock_o(rd_clock_i));
	fifo_chan dut (.*);
	// Second channel never written, so it must stay empty
	fifo_chan dut_b (.*, .wr_enable_first_i(1'b1), .rd_data_bus_o(),
		.rd_data_oe_n_o(), .empty_flag_n_o(ef_b), .almost_empty_flag_n_o(),
		.almost_full_flag_n_o(), .full_flag_n_o());
	initial forever #5 sys_clk_i = ~sys_clk_i;
	task automatic chk(input logic [DATA_W-1:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	function automatic logic [3:0] flags(int n);
		return {n != 0, n > off[0], n < DEPTH - off[1], n != DEPTH};
	endfunction : flags
	task automatic chkf;
		chk({empty_flag_n_o, almost_empty_flag_n_o,
			almost_full_flag_n_o, full_flag_n_o}, flags(fifo_q.size()));
	endtask : chkf
	// Set pins while the pin clock is low, hold them over one rise
	task automatic op(input bit r, input logic a, b, l, [DATA_W-1:0] d);
		@(negedge (r ? rd_clock_i : wr_clock_i));
		@(posedge sys_clk_i);
		wr_enable2_or_load_i <= r ? l : b;
		{rd_enable_first_i, rd_enable_second_i} <= r ? {a, b} : 2'h3;
		wr_enable_first_i <= r ? 1'b1 : a;
		wr_data_bus_i <= d;
		@(negedge (r ? rd_clock_i : wr_clock_i));
		@(posedge sys_clk_i);
		{wr_enable_first_i, wr_enable2_or_load_i} <= 2'h3;
		{rd_enable_first_i, rd_enable_second_i} <= 2'h3;
		repeat (14) @(posedge sys_clk_i);
	endtask : op
	task automatic wr(input logic a, b, [DATA_W-1:0] d);
		op(0, a, b, 1, d);
		if (!a && b && fifo_q.size() < DEPTH)
			fifo_q.push_back(d);
		else if (!a && !b && pf)
		begin
			off[tog] = d[ADDR_W-1:0];
			tog = !tog;
		end
		chkf();
	endtask : wr
	task automatic rd(input logic a, b, l);
		op(1, a, b, l, '0);
		if (!a && !b && pf && !l)
		begin
			chk(rd_data_bus_o, {1'b0, off[tog]});
			tog = !tog;
		end
		else if (!a && !b && fifo_q.size() > 0)
			chk(rd_data_bus_o, fifo_q.pop_front());
		chkf();
	endtask : rd
	task automatic chan_rst(input logic l);
		rs_n_i <= 0;
		wr_enable2_or_load_i <= l;
		repeat (5) @(posedge sys_clk_i);
		rs_n_i <= 1;
		repeat (3) @(posedge sys_clk_i);
		wr_enable2_or_load_i <= 1;
		repeat (4) @(posedge sys_clk_i);
		fifo_q.delete();
		off = '{AE_OFF_RST, AF_OFF_RST};
		tog = 0;
		pf = !l;
		chkf();
	endtask : chan_rst
	task automatic stop_test;
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	initial
	begin
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 0;
		out_drive_n_i <= 0;
		chan_rst(1);
		chk(rd_data_oe_n_o, 1'b0);
		repeat (260) wr(0, 1, 9'($random(seed)));
		chk(ef_b, 1'b0);
		repeat (600)
			if ($random(seed) & 1)
				wr(1'($random(seed)), 1'($random(seed)), 9'($random(seed)));
			else
				rd(1'($random(seed)), 1'($random(seed)), 1);
		repeat (260) rd(0, 0, 1);
		out_drive_n_i <= 1;
		repeat (5) @(posedge sys_clk_i);
		chk(rd_data_oe_n_o, 1'b1);
		chan_rst(0);
		wr(0, 0, 9'h014);
		wr(0, 0, 9'h003);
		rd(0, 0, 0);
		repeat (256) wr(0, 1, 9'($random(seed)));
		stop_test();
	end
	initial
	begin
		#1000000;
		num_errors++;
		stop_test();
	end
endmodule : tb
